/* File: verilog/fsq_pkg.sv */
// Constants and types shared by the flash instruction sequencer
// Contract
// (R1) Whole-array erase on C7h or 60h sets all bytes to FFh, only with latch set
// (R2) Whole-array erase runs only when chip select rises right after bit eight
// (R3) During whole-array erase status shows busy; at end busy drops, latch clears
// (R4) Whole-array erase refused when any page is protected
// (R5) Suspend 75h honoured only during sector/block erase or program, not paused
// (R6) Accepted suspend sets paused_flag at once, busy clears within pause latency
// (R7) While paused, reject 01h, 44h, 42h, all erases, 02h and 32h
// (R8) Host waits pause latency after resume before another suspend
// (R9) Power loss clears suspended state and paused_flag; later resume ignored
// (R10) Resume 7Ah accepted only when paused and not busy
// (R11) Accepted resume clears paused_flag at once, busy returns within 200 ns
// (R12) B9h with chip select rising after bit eight enters power-down
// (R13) In power-down only ABh is recognised, status reads included
// (R14) Device starts in normal mode after power-up
// (R15) Host keeps chip select high for wake time after bare ABh
// (R16) ABh plus three dummy bytes shifts device ID out repeatedly, MSB first
// (R17) Host keeps chip select high for ID wake time after release with ID
// (R18) Release/ID opcode ignored while busy, running cycle unaffected
// (R19) 90h: address bit zero picks which ID comes first; IDs alternate
// (R20) 92h: address and mode in two bits per clock; IDs out two bits
// (R21) 94h: address and mode four bits per clock, four dummies; IDs four bits
// (R22) Host drives mode bits as Fxh in dual and quad ID reads
package fsq_pkg;
  localparam logic [7:0] OP_CE_A = 8'hC7;
  localparam logic [7:0] OP_CE_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_PWR_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_ID_X1 = 8'h90;
  localparam logic [7:0] OP_ID_X2 = 8'h92;
  localparam logic [7:0] OP_ID_X4 = 8'h94;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_SREG_ERASE = 8'h44;
  localparam logic [7:0] OP_SREG_PROG = 8'h42;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QPAGE_PROG = 8'h32;

  localparam logic [5:0] CMD_CLKS = 6'h08;
  localparam logic [5:0] ADDR_CLKS_X1 = 6'h18;
  localparam logic [5:0] ADDR_CLKS_X2 = 6'h10;
  localparam logic [5:0] ADDR_CLKS_X4 = 6'h08;
  localparam logic [5:0] DUMMY_CLKS_X4 = 6'h04;
  localparam logic [5:0] DUMMY_CLKS_REL = 6'h18;

  localparam int MCLK_MHZ = 25;
  localparam int RESUME_WIP_NS = 200;
  localparam int RESUME_WIP_CYC = (RESUME_WIP_NS * MCLK_MHZ) / 1000;

  localparam logic [31:0] CE_CYC_DEF = 32'h0001_0000;
  localparam logic [31:0] DP_CYC_DEF = 32'h0000_0040;
  localparam logic [31:0] RES1_CYC_DEF = 32'h0000_0040;
  localparam logic [31:0] RES2_CYC_DEF = 32'h0000_0040;
  localparam logic [31:0] SUS_CYC_DEF = 32'h0000_0100;

  typedef enum logic [2:0] {
    FSQ_PH_CMD, FSQ_PH_ADDR, FSQ_PH_DUMMY, FSQ_PH_DATA, FSQ_PH_SKIP
  } fsq_phase_e;
  typedef enum logic [1:0] {FSQ_LN_X1, FSQ_LN_X2, FSQ_LN_X4} fsq_lane_e;
  typedef enum logic [1:0] {
    FSQ_PW_ON, FSQ_PW_ENTER, FSQ_PW_DOWN, FSQ_PW_WAKE
  } fsq_pwr_e;
endpackage

/* File: verilog/fsq_tmr_if.sv */
// Start and done signals between the sequencer and a cycle timer
`timescale 1ns/1ps
interface fsq_tmr_if;
  logic start;
  logic [31:0] load;
  logic done;
  logic busy;
  modport owner (output start, output load, input done, input busy);
  modport timer (input start, input load, output done, output busy);
endinterface

/* File: verilog/fsq_sync.sv */
// Two-flop synchroniser for pins from outside the MCLK domain
`timescale 1ns/1ps
module fsq_sync #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fsq_sync_s;
  fsq_sync_s r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule

/* File: verilog/fsq_timer.sv */
// One-shot down counter; done pulses once after the loaded cycle count
`timescale 1ns/1ps
module fsq_timer (
  input wire logic clk,
  input wire logic rst_n,
  fsq_tmr_if.timer t
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic done;
  } fsq_tmr_s;
  fsq_tmr_s r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (t.start) begin
      // A zero load would never finish, so it counts as one cycle
      r_next.cnt = (t.load == 32'h0000_0000) ? 32'h0000_0001 : t.load;
      r_next.busy = 1'b1;
    end else if (r_reg.busy) begin
      r_next.cnt = r_reg.cnt - 32'h0000_0001;
      if (r_reg.cnt == 32'h0000_0001) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign t.busy = r_reg.busy;
  assign t.done = r_reg.done;
endmodule

/* File: verilog/fsq_top.sv */
// Flash instruction sequencer: chip erase, suspend, power-down and ID reads
`timescale 1ns/1ps
module fsq_top
  import fsq_pkg::*;
#(
  parameter logic [31:0] CE_CYCLES = CE_CYC_DEF,
  parameter logic [31:0] DP_CYCLES = DP_CYC_DEF,
  parameter logic [31:0] RES1_CYCLES = RES1_CYC_DEF,
  parameter logic [31:0] RES2_CYCLES = RES2_CYC_DEF,
  parameter logic [31:0] SUS_CYCLES = SUS_CYC_DEF,
  // Arbitrary identity values
  parameter logic [7:0] MFR_ID = 8'h5A,
  parameter logic [7:0] DEV_ID = 8'h3C
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] DQ_I,
  output logic [3:0] DQ_O,
  output logic [3:0] DQ_OE,
  input wire logic WEL_IN,
  input wire logic PROTECT_ANY,
  input wire logic EXT_BUSY,
  output logic EXT_HOLD,
  output logic WEL_CLEAR,
  output logic ERASE_ALL,
  output logic WRITE_IN_PROGRESS,
  output logic PAUSED,
  output logic POWER_DOWN,
  output logic [7:0] OPCODE,
  output logic OPCODE_STB
);
  localparam int ResMax = RESUME_WIP_CYC;

  typedef struct packed {
    fsq_phase_e ph;
    fsq_lane_e ln;
    logic [5:0] pc;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [7:0] op;
    logic [15:0] osh;
    logic [3:0] dq_o;
    logic [3:0] dq_oe;
    logic sclk_d;
    logic cs_d;
    fsq_pwr_e pw;
    logic ce_busy;
    logic paused;
    logic wip_off;
    logic write_in_progress;
    logic wel_clr;
    logic [7:0] opc;
    logic opc_stb;
    logic ce_go;
    logic sus_go;
    logic pw_go;
    logic [31:0] pw_ld;
  } fsq_state_s;

  fsq_state_s r_reg, r_next;
  logic [5:0] pins;
  logic sclk_s;
  logic cs_s;
  logic [3:0] dq_s;
  logic rise;
  logic fall;
  logic frame_end;
  logic exact8;
  logic [7:0] op_now;
  logic own_op;
  fsq_tmr_if ce_t ();
  fsq_tmr_if pw_t ();
  fsq_tmr_if sus_t ();

  // Opcodes locked out while an erase or program is suspended
  function automatic logic paused_reject(input logic [7:0] op);
    paused_reject = (op == OP_WR_STATUS) || (op == OP_SREG_ERASE) ||
      (op == OP_SREG_PROG) || (op == OP_SECT_ERASE) ||
      (op == OP_BLK32_ERASE) || (op == OP_BLK64_ERASE) ||
      (op == OP_CE_A) || (op == OP_CE_B) ||
      (op == OP_PAGE_PROG) || (op == OP_QPAGE_PROG);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  fsq_sync #(.W(6)) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d({SCLK, CS_N, DQ_I}),
    .q(pins)
  );
  assign sclk_s = pins[5];
  assign cs_s = pins[4];
  assign dq_s = pins[3:0];
  // Sampling limits the serial clock to well below MCLK/2
  assign rise = sclk_s & ~r_reg.sclk_d & ~cs_s;
  assign fall = ~sclk_s & r_reg.sclk_d & ~cs_s;
  assign frame_end = cs_s & ~r_reg.cs_d;
  assign exact8 = (r_reg.cnt == CMD_CLKS);
  assign op_now = {r_reg.sh[6:0], dq_s[0]};
  assign own_op = (op_now == OP_CE_A) || (op_now == OP_CE_B) ||
    (op_now == OP_SUSPEND) || (op_now == OP_RESUME) ||
    (op_now == OP_PWR_DOWN) || (op_now == OP_RELEASE) ||
    (op_now == OP_ID_X1) || (op_now == OP_ID_X2) || (op_now == OP_ID_X4);

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  assign ce_t.start = r_reg.ce_go;
  assign ce_t.load = CE_CYCLES;
  assign pw_t.start = r_reg.pw_go;
  assign pw_t.load = r_reg.pw_ld;
  assign sus_t.start = r_reg.sus_go;
  assign sus_t.load = SUS_CYCLES;

  fsq_timer u_ce_tmr (.clk(MCLK), .rst_n(RST_N), .t(ce_t));
  fsq_timer u_pw_tmr (.clk(MCLK), .rst_n(RST_N), .t(pw_t));
  fsq_timer u_sus_tmr (.clk(MCLK), .rst_n(RST_N), .t(sus_t));

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.sclk_d = sclk_s;
    r_next.cs_d = cs_s;
    r_next.wel_clr = 1'b0;
    r_next.opc_stb = 1'b0;
    r_next.ce_go = 1'b0;
    r_next.sus_go = 1'b0;
    r_next.pw_go = 1'b0;
    if (cs_s) begin
      r_next.ph = FSQ_PH_CMD;
      r_next.pc = '0;
      r_next.cnt = '0;
      r_next.dq_oe = '0;
      // One-byte instructions act only when the frame held exactly 8 clocks
      if (frame_end && exact8 && r_reg.pw == FSQ_PW_ON) begin
        if ((r_reg.op == OP_CE_A || r_reg.op == OP_CE_B) && WEL_IN &&
            !PROTECT_ANY && !r_reg.write_in_progress && !r_reg.paused) begin
          r_next.ce_busy = 1'b1; // [R1] [R2] [R4] [R7]
          r_next.ce_go = 1'b1;
        end
        if (r_reg.op == OP_PWR_DOWN && !r_reg.write_in_progress) begin
          r_next.pw = FSQ_PW_ENTER; // [R12]
          r_next.pw_go = 1'b1;
          r_next.pw_ld = DP_CYCLES;
        end
        if (r_reg.op == OP_SUSPEND && EXT_BUSY && !r_reg.ce_busy &&
            !r_reg.paused && r_reg.write_in_progress) begin
          r_next.paused = 1'b1; // [R5] [R6]
          r_next.sus_go = 1'b1;
        end
        if (r_reg.op == OP_RESUME && r_reg.paused && !r_reg.write_in_progress) begin
          r_next.paused = 1'b0; // [R10] [R11]
          r_next.wip_off = 1'b0;
        end
      end
      // Release: bare opcode or with ID readout, each with its own wake
      if (frame_end && r_reg.pw == FSQ_PW_DOWN &&
          r_reg.cnt >= CMD_CLKS && r_reg.op == OP_RELEASE && !r_reg.write_in_progress) begin
        r_next.pw = FSQ_PW_WAKE; // [R15] [R17] [R18]
        r_next.pw_go = 1'b1;
        r_next.pw_ld = exact8 ? RES1_CYCLES : RES2_CYCLES;
      end
    end else begin
      if (rise) begin
        if (r_reg.cnt != 6'h3F) begin
          r_next.cnt = r_reg.cnt + 6'h01;
        end
        unique case (r_reg.ph)
          FSQ_PH_CMD: begin
            r_next.sh = {r_reg.sh[30:0], dq_s[0]};
            r_next.pc = r_reg.pc + 6'h01;
            if (r_reg.pc == CMD_CLKS - 6'h01) begin
              r_next.op = op_now;
              r_next.pc = '0;
              r_next.ph = FSQ_PH_SKIP;
              r_next.ln = FSQ_LN_X1;
              if (r_reg.pw == FSQ_PW_ON) begin
                if (op_now == OP_ID_X1) begin
                  r_next.ph = FSQ_PH_ADDR; // [R19]
                end else if (op_now == OP_ID_X2) begin
                  r_next.ph = FSQ_PH_ADDR; // [R20]
                  r_next.ln = FSQ_LN_X2;
                end else if (op_now == OP_ID_X4) begin
                  r_next.ph = FSQ_PH_ADDR; // [R21]
                  r_next.ln = FSQ_LN_X4;
                end
              end
              // Readout of the ID also works from power-down, never when busy
              if (op_now == OP_RELEASE && !r_reg.write_in_progress &&
                  (r_reg.pw == FSQ_PW_ON || r_reg.pw == FSQ_PW_DOWN)) begin
                r_next.ph = FSQ_PH_DUMMY; // [R16] [R18]
              end
              if (!own_op && r_reg.pw == FSQ_PW_ON &&
                  !(r_reg.paused && paused_reject(op_now))) begin
                r_next.opc = op_now; // [R7] [R13]
                r_next.opc_stb = 1'b1;
              end
            end
          end
          FSQ_PH_ADDR: begin
            unique case (r_reg.ln)
              FSQ_LN_X1: r_next.sh = {r_reg.sh[30:0], dq_s[0]};
              FSQ_LN_X2: r_next.sh = {r_reg.sh[29:0], dq_s[1:0]};
              FSQ_LN_X4: r_next.sh = {r_reg.sh[27:0], dq_s};
            endcase
            r_next.pc = r_reg.pc + 6'h01;
            if ((r_reg.ln == FSQ_LN_X1 && r_reg.pc == ADDR_CLKS_X1 - 6'h01) ||
                (r_reg.ln == FSQ_LN_X2 && r_reg.pc == ADDR_CLKS_X2 - 6'h01) ||
                (r_reg.ln == FSQ_LN_X4 &&
                 r_reg.pc == ADDR_CLKS_X4 - 6'h01)) begin
              r_next.pc = '0;
              // Address bit 0 picks which ID leads; mode bits trail it
              if ((r_reg.ln == FSQ_LN_X1) ? r_next.sh[0] : r_next.sh[8]) begin
                r_next.osh = {DEV_ID, MFR_ID}; // [R19]
              end else begin
                r_next.osh = {MFR_ID, DEV_ID};
              end
              r_next.ph = (r_reg.ln == FSQ_LN_X4) ? FSQ_PH_DUMMY
                                                  : FSQ_PH_DATA; // [R21]
            end
          end
          FSQ_PH_DUMMY: begin
            r_next.pc = r_reg.pc + 6'h01;
            if (r_reg.op == OP_RELEASE &&
                r_reg.pc == DUMMY_CLKS_REL - 6'h01) begin
              r_next.osh = {DEV_ID, DEV_ID}; // [R16]
              r_next.ph = FSQ_PH_DATA;
            end else if (r_reg.op != OP_RELEASE &&
                         r_reg.pc == DUMMY_CLKS_X4 - 6'h01) begin
              r_next.ph = FSQ_PH_DATA;
            end
          end
          FSQ_PH_DATA, FSQ_PH_SKIP: begin
          end
        endcase
      end
      // Shift out on falling edges; the register rotates so IDs repeat
      if (fall && r_reg.ph == FSQ_PH_DATA) begin
        unique case (r_reg.ln)
          FSQ_LN_X1: begin
            r_next.dq_o = {2'b00, r_reg.osh[15], 1'b0}; // [R16] [R19]
            r_next.dq_oe = 4'h2;
            r_next.osh = {r_reg.osh[14:0], r_reg.osh[15]};
          end
          FSQ_LN_X2: begin
            r_next.dq_o = {2'b00, r_reg.osh[15:14]}; // [R20]
            r_next.dq_oe = 4'h3;
            r_next.osh = {r_reg.osh[13:0], r_reg.osh[15:14]};
          end
          FSQ_LN_X4: begin
            r_next.dq_o = r_reg.osh[15:12]; // [R21]
            r_next.dq_oe = 4'hF;
            r_next.osh = {r_reg.osh[11:0], r_reg.osh[15:12]};
          end
        endcase
      end
    end
    if (ce_t.done) begin
      r_next.ce_busy = 1'b0; // [R3]
      r_next.wel_clr = 1'b1;
    end
    if (pw_t.done) begin
      if (r_reg.pw == FSQ_PW_ENTER) begin
        r_next.pw = FSQ_PW_DOWN; // [R12]
      end else if (r_reg.pw == FSQ_PW_WAKE) begin
        r_next.pw = FSQ_PW_ON;
      end
    end
    if (sus_t.done && r_next.paused) begin
      r_next.wip_off = 1'b1; // [R6]
    end
    // Busy follows the erase timer or the external engine, masked once the pause latency has run out
    r_next.write_in_progress = r_next.ce_busy |
                 (EXT_BUSY & ~r_next.wip_off); // [R3] [R6] [R11]
  end

  // Power-on reset leaves normal mode with nothing suspended
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      r_reg <= '{ph: FSQ_PH_CMD, ln: FSQ_LN_X1, pw: FSQ_PW_ON, // [R14] [R9]
                 cs_d: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign DQ_O = r_reg.dq_o;
  assign DQ_OE = r_reg.dq_oe;
  assign EXT_HOLD = r_reg.paused;
  assign WEL_CLEAR = r_reg.wel_clr;
  assign ERASE_ALL = r_reg.ce_busy;
  assign WRITE_IN_PROGRESS = r_reg.write_in_progress;
  assign PAUSED = r_reg.paused;
  assign POWER_DOWN = (r_reg.pw != FSQ_PW_ON);
  assign OPCODE = r_reg.opc;
  assign OPCODE_STB = r_reg.opc_stb;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ce_accept: assert property ( // [R1]
    @(posedge MCLK) disable iff (!RST_N)
    $rose(r_reg.ce_busy) |-> $past(WEL_IN) && !$past(PROTECT_ANY))
    else $error("chip erase started without latch or with protection");

  a_ce_exact8: assert property ( // [R2]
    @(posedge MCLK) disable iff (!RST_N)
    $rose(r_reg.ce_busy) |-> $past(r_reg.cnt) == CMD_CLKS && $past(cs_s))
    else $error("chip erase started from a frame not exactly 8 clocks");

  a_ce_wip_end: assert property ( // [R3]
    @(posedge MCLK) disable iff (!RST_N)
    $fell(r_reg.ce_busy) |-> r_reg.wel_clr ##1 !r_reg.wel_clr)
    else $error("chip erase end did not pulse latch clear once");

  a_ce_busy_wip: assert property ( // [R3]
    @(posedge MCLK) disable iff (!RST_N)
    r_reg.ce_busy |-> r_reg.write_in_progress)
    else $error("busy flag low during chip erase");

  a_susp_accept: assert property ( // [R5]
    @(posedge MCLK) disable iff (!RST_N)
    $rose(r_reg.paused) |-> $past(r_reg.write_in_progress) && $past(EXT_BUSY) &&
      !$past(r_reg.ce_busy))
    else $error("suspend accepted with no erase or program running");

  a_susp_latency: assert property ( // [R6]
    @(posedge MCLK) disable iff (!RST_N)
    r_reg.wip_off && r_reg.paused |-> !r_reg.write_in_progress)
    else $error("busy flag still set after pause latency");

  a_susp_reject: assert property ( // [R7]
    @(posedge MCLK) disable iff (!RST_N)
    r_reg.opc_stb && r_reg.paused |-> !paused_reject(r_reg.opc))
    else $error("locked opcode forwarded while paused");

  a_resume_cond: assert property ( // [R10]
    @(posedge MCLK) disable iff (!RST_N)
    $fell(r_reg.paused) |-> !$past(r_reg.write_in_progress) && $past(r_reg.op) == OP_RESUME)
    else $error("resume accepted while busy or without resume opcode");

  a_resume_wip: assert property ( // [R11]
    @(posedge MCLK) disable iff (!RST_N)
    $fell(r_reg.paused) && EXT_BUSY |-> ##[0:ResMax] r_reg.write_in_progress)
    else $error("busy flag not back within 200 ns of resume");

  a_pd_entry: assert property ( // [R12]
    @(posedge MCLK) disable iff (!RST_N)
    $rose(r_reg.pw == FSQ_PW_DOWN) |-> $past(r_reg.pw) == FSQ_PW_ENTER)
    else $error("power-down reached without entry phase");

  a_pd_silent: assert property ( // [R13]
    @(posedge MCLK) disable iff (!RST_N)
    r_reg.pw != FSQ_PW_ON |-> !r_reg.opc_stb && !$rose(r_reg.ce_busy))
    else $error("instruction acted on during power-down");

  a_rel_not_busy: assert property ( // [R18]
    @(posedge MCLK) disable iff (!RST_N)
    $rose(r_reg.ph == FSQ_PH_DUMMY) && r_reg.op == OP_RELEASE
      |-> !$past(r_reg.write_in_progress))
    else $error("release opcode taken while busy");

  a_oe_data: assert property ( // [R16]
    @(posedge MCLK) disable iff (!RST_N)
    r_reg.dq_oe != 4'h0 |-> r_reg.ph == FSQ_PH_DATA)
    else $error("data pins driven outside readout");
endmodule

/* File: testbench/fsq_host.sv */
// SPI host model that frames instructions for the sequencer
`timescale 1ns/1ps
module fsq_host (
  input wire logic mclk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq,
  input wire logic [3:0] dq_o,
  input wire logic [3:0] dq_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq = 4'h5;
  end
  // -----------------------------
  // Link timing
  // -----------------------------
  task automatic hw(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Eight MCLK per SCLK; read just before the next fall, as sync lag
  // in the device makes earlier sampling unsafe
  task automatic clk1(input logic [3:0] d, output logic [7:0] q);
    dq = d;
    hw(4);
    sclk = 1'b1;
    hw(4);
    q = {dq_oe, dq_o};
    sclk = 1'b0;
  endtask
  task automatic start();
    cs_n = 1'b0;
    hw(4);
  endtask
  // Chip select rises right after the last clock
  task automatic fin();
    hw(2);
    cs_n = 1'b1;
    dq = ~dq;
    hw(8);
  endtask
  task automatic snd(input logic [31:0] v, input int n, input int w);
    logic [7:0] q;
    for (int i = 0; i < n; i++) begin
      case (w)
        1: clk1({~dq[3:1], v[31]}, q);
        2: clk1({~dq[3:2], v[31:30]}, q);
        default: clk1(v[31:28], q);
      endcase
      v = v << w;
    end
  endtask
  // Released lines toggle every clock so no stale value looks valid
  task automatic rd(input int n, input int w, output logic [31:0] r,
                    output logic [3:0] oe);
    logic [7:0] q;
    r = '0;
    oe = '0;
    for (int i = 0; i < n; i++) begin
      clk1(~dq, q);
      oe |= q[7:4];
      case (w)
        1: r = {r[30:0], q[1]};
        2: r = {r[29:0], q[1:0]};
        default: r = {r[27:0], q[3:0]};
      endcase
    end
  endtask
endmodule

/* File: testbench/flash_erase_suspend_powerdown_id_bench.sv */
// Self-checking bench for the flash instruction sequencer
`timescale 1ns/1ps
module flash_erase_suspend_powerdown_id_bench;
  import fsq_pkg::*;
  localparam logic [31:0] CE = 32'h0000_00C8;
  localparam logic [31:0] DP = 32'h0000_0008;
  localparam logic [31:0] RES1 = 32'h0000_0008;
  localparam logic [31:0] RES2 = 32'h0000_000C;
  localparam logic [31:0] PAUSED_FLAG = 32'h0000_000A;
  localparam logic [7:0] MFR = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3C; // Arbitrary value
  logic mclk, rst_n, sclk, cs_n, wel_in, protect_any, ext_busy;
  logic ext_hold, wel_clear, erase_all, write_in_progress, paused, power_down;
  logic opcode_stb;
  logic [3:0] dq_i, dq_o, dq_oe;
  logic [7:0] opcode;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int nclr = 0;
  int nstb = 0;
  logic [7:0] blk [10] = '{OP_WR_STATUS, OP_SREG_ERASE, OP_SREG_PROG,
    OP_SECT_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE, OP_CE_A, OP_CE_B,
    OP_PAGE_PROG, OP_QPAGE_PROG};
  logic [7:0] id_op [3] = '{OP_ID_X1, OP_ID_X2, OP_ID_X4};
  logic [3:0] oes [3] = '{4'h2, 4'h3, 4'hF};

  fsq_top #(.CE_CYCLES(CE), .DP_CYCLES(DP), .RES1_CYCLES(RES1),
    .RES2_CYCLES(RES2), .SUS_CYCLES(PAUSED_FLAG), .MFR_ID(MFR), .DEV_ID(DEV)
  ) u_dut (.MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n),
    .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe), .WEL_IN(wel_in),
    .PROTECT_ANY(protect_any), .EXT_BUSY(ext_busy),
    .EXT_HOLD(ext_hold), .WEL_CLEAR(wel_clear), .ERASE_ALL(erase_all),
    .WRITE_IN_PROGRESS(write_in_progress), .PAUSED(paused), .POWER_DOWN(power_down),
    .OPCODE(opcode), .OPCODE_STB(opcode_stb));
  fsq_host u_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .dq(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    nclr <= nclr + int'(wel_clear === 1'b1);
    nstb <= nstb + int'(opcode_stb === 1'b1);
    if (cyc == 40000) begin
      mismatches++;
      test_done();
    end
  end
  // -----------------------------
  // Helpers
  // -----------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] exp_id(input logic a);
    return a ? {DEV, MFR, DEV, MFR} : {MFR, DEV, MFR, DEV};
  endfunction
  task automatic op1(input logic [7:0] op);
    u_host.start();
    u_host.snd({op, 24'h00_0000}, 8, 1);
    u_host.fin();
  endtask
  task automatic idrd(input logic [7:0] op, input logic [31:0] v,
      input int n, input int w, input int dm, input int rn,
      output logic [31:0] r, output logic [3:0] oe);
    u_host.start();
    u_host.snd({op, 24'h00_0000}, 8, 1);
    u_host.snd(v, n, w);
    u_host.snd(32'h0000_0000, dm, w);
    u_host.rd(rn, w, r, oe);
    u_host.fin();
  endtask
  task automatic test_done();
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // -----------------------------
  // Scenarios
  // -----------------------------
  initial begin
    logic [31:0] r;
    logic [3:0] oe;
    int s;
    rst_n = 1'b0;
    wel_in = 1'b1;
    protect_any = 1'b0;
    ext_busy = 1'b0;
    void'($urandom(7));
    idle(10);
    rst_n = 1'b1;
    idle(4);
    chk("power_down", 0, power_down);
    for (int k = 0; k < 2; k++) begin
      s = nclr;
      op1(k == 0 ? OP_CE_A : OP_CE_B);
      chk("erase_all", 1, erase_all);
      chk("wip", 1, write_in_progress);
      idle(int'(CE) - 40);
      chk("erase_all", 1, erase_all);
      idle(60);
      chk("wip", 0, write_in_progress);
      chk("wel_clear", 1, nclr - s);
    end
    // Latch clear, protected page, then a nine-clock frame
    for (int k = 0; k < 3; k++) begin
      wel_in = (k != 0);
      protect_any = (k == 1);
      u_host.start();
      u_host.snd({($urandom % 2) ? OP_CE_A : OP_CE_B, 24'h00_0000},
                 8 + int'(k == 2), 1);
      u_host.fin();
      chk("erase_refused", 0, erase_all);
    end
    protect_any = 1'b0;
    ext_busy = 1'b1;
    idle(4);
    s = nstb;
    op1(OP_SUSPEND);
    chk("paused", 1, paused);
    chk("ext_hold", 1, ext_hold);
    idle(int'(PAUSED_FLAG) + 8);
    chk("wip", 0, write_in_progress);
    foreach (blk[i]) op1(blk[i]);
    chk("blocked", s, nstb);
    chk("erase_all", 0, erase_all);
    op1(8'h05);
    chk("forwarded", s + 1, nstb);
    chk("opcode", 8'h05, opcode);
    op1(OP_RESUME);
    chk("paused", 0, paused);
    chk("wip", 1, write_in_progress);
    idle(int'(PAUSED_FLAG)); // Spacing before the next suspend
    op1(OP_SUSPEND);
    chk("paused", 1, paused);
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(4);
    chk("paused", 0, paused);
    op1(OP_RESUME);
    chk("paused", 0, paused);
    idrd(OP_RELEASE, 0, 24, 1, 0, 16, r, oe);
    chk("busy_oe", 0, oe);
    chk("wip", 1, write_in_progress);
    ext_busy = 1'b0;
    idle(4);
    op1(OP_SUSPEND);
    chk("paused", 0, paused);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        op1(OP_PWR_DOWN);
        chk("power_down", 1, power_down);
        idle(int'(DP) + 4);
      end
      idrd(OP_RELEASE, 0, 24, 1, 0, 16, r, oe);
      chk("dev_id", {16'h0000, DEV, DEV}, r);
      idle(int'(RES2)); // Chip select stays high
      chk("power_down", 0, power_down);
    end
    op1(OP_PWR_DOWN);
    idle(int'(DP) + 4);
    s = nstb;
    op1(8'h05);
    idrd(OP_ID_X1, 0, 24, 1, 0, 8, r, oe);
    chk("pd_oe", 0, oe);
    chk("pd_forward", s, nstb);
    op1(OP_RELEASE);
    idle(int'(RES1)); // Chip select stays high
    chk("power_down", 0, power_down);
    for (int a = 0; a < 2; a++) begin
      for (int k = 0; k < 3; k++) begin
        // Mode bits high nibble F
        idrd(id_op[k], {23'h00_0000, a[0], 4'hF, 4'($urandom)},
             k == 0 ? 24 : 32 >> k, 1 << k, k == 2 ? 4 : 0,
             32 >> k, r, oe);
        chk("ids", exp_id(a[0]), r);
        chk("id_oe", oes[k], oe);
      end
    end
    test_done();
  end
endmodule
